/* File: dv/tb_gpt_timer_set.sv */
// tb_gpt_timer_set: self-checking bench for the timer set, random periods
// assumes gpt_pkg is compiled first; the bench drives the register port itself
`timescale 1ns/1ps
module tb_gpt_timer_set;
    // ==========================================================
    // signals
    logic clk;
    logic srst;
    gpt_pkg::gpt_bus_req_t bus_req;
    logic [15:0] rd_data;
    logic idle_mode;
    logic sleep_mode;
    logic [8:0] ext_pin;
    logic [8:0] irq_flag;
    logic [1:0] conv_trigger;
    logic [1:0] dma_trigger;
    logic [15:0] timebase_lo;
    logic [15:0] timebase_hi;
    int errors;        // mismatches seen
    int total_checks;  // comparisons made
    int seed;          // random seed
    int lat;           // measured wait in cycles
    int want;          // expected wait in cycles
    int n;             // random period
    logic [15:0] v;    // first read value
    logic [15:0] w;    // second read value
    logic [3:0] trig_seen;  // sticky copy of dma and converter triggers
    logic trig_clr;         // empties the sticky copy
    logic [15:0] msk [3] = '{gpt_pkg::MASK_SOLO, gpt_pkg::MASK_EVEN, gpt_pkg::MASK_ODD};

    gpt_timer_set #(.NUM_PAIRS(4)) uut (
        .clk(clk), .srst(srst), .bus_req(bus_req), .rd_data(rd_data),
        .idle_mode(idle_mode), .sleep_mode(sleep_mode), .ext_pin(ext_pin),
        .irq_flag(irq_flag), .conv_trigger(conv_trigger), .dma_trigger(dma_trigger),
        .timebase_lo(timebase_lo), .timebase_hi(timebase_hi)
    );  // uut

    // clock, 10 ns period
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // remember trigger pulses between checks
    always @(posedge clk) begin
        if (srst || trig_clr) begin
            trig_seen <= 4'h0;
        end else begin
            trig_seen <= trig_seen | {dma_trigger, conv_trigger};
        end
    end

    // ==========================================================
    // bus and check tasks
    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus_req.wr <= 1'b0;
    endtask
    task automatic rd(input logic [5:0] a, output logic [15:0] d);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus_req.rd <= 1'b0;
        #1 d = rd_data;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rchk(input string nm, input logic [5:0] a, input logic [15:0] e);
        rd(a, v);
        chk(nm, e, v);
    endtask
    // bounded wait for one flag bit
    task automatic wait_flag(input int b, input int lim, output int c);
        c = 0;
        while (irq_flag[b] !== 1'b1 && c < lim) begin
            @(posedge clk);
            c++;
        end
    endtask
    // drive one pin level, then hold it
    task automatic pins(input int i, input logic lv, input int hold);
        @(posedge clk);
        ext_pin[i] <= lv;
        repeat (hold) @(posedge clk);
    endtask
    // empty the sticky trigger copy at one edge
    task automatic clear_trig;
        @(posedge clk);
        trig_clr <= 1'b1;
        @(posedge clk);
        trig_clr <= 1'b0;
    endtask
    // prescale ratio of a select code
    function automatic int ratio(input int ps);
        return ps == 3 ? 256 : ps == 2 ? 64 : ps == 1 ? 8 : 1;
    endfunction
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // watchdog, well beyond the expected run
    initial begin
        #(90000 * 10);
        errors++;
        $display("mismatch watchdog expected finish seen timeout");
        report_and_stop();
    end

    // ==========================================================
    // main sequence
    initial begin
        seed = 32'hdb611ec8;
        srst = 1'b1;
        idle_mode = 1'b0;
        sleep_mode = 1'b0;
        ext_pin = '0;
        bus_req = '0;
        trig_clr = 1'b0;
        errors = 0;
        total_checks = 0;
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        // reset values
        rchk("ctrl0", 6'h00, 16'h0000);
        rchk("period0", 6'h01, 16'hFFFF);
        rchk("count0", 6'h02, 16'h0000);
        // writable bits of solo, even and odd control words
        foreach (msk[i]) begin
            wr({i[3:0], 2'h0}, 16'hFFFF);
            rchk("ctrl mask", {i[3:0], 2'h0}, msk[i]);
            wr({i[3:0], 2'h0}, 16'h0000);
        end
        // unmapped and reserved places
        wr(6'h3C, 16'hFFFF);
        rchk("unmapped", 6'h3C, 16'h0000);
        rchk("reserved word", 6'h07, 16'h0000);
        $display("test registers done");
        // period match timing for every prescale code, random period
        for (int ps = 0; ps < 4; ps++) begin
            n = 2 + ($unsigned($random(seed)) % 8);
            wr(6'h01, n[15:0]);
            wr(6'h02, 16'h0000);
            wr(6'h03, 16'h0001);
            wr(6'h00, {8'h80, 2'b00, ps[1:0], 4'h0});
            wait_flag(0, 3000, lat);
            want = (n + 1) * ratio(ps);
            chk("match time", 16'h0001, {15'h0, lat >= want - 1 && lat <= want + 3});
            rd(6'h02, v);
            chk("count wrap", 16'h0001, {15'h0, v <= n[15:0]});
            wr(6'h00, 16'h0000);
            rd(6'h02, v);
            rchk("stopped count", 6'h02, v);
            wr(6'h03, 16'h0001);
            @(posedge clk);
            chk("flag clear", 16'h0000, {15'h0, irq_flag[0]});
        end
        $display("test prescale done");
        // idle halt and idle run
        wr(6'h01, 16'hFFFF);
        @(posedge clk) idle_mode <= 1'b1;
        wr(6'h00, 16'hA000);
        rd(6'h02, v);
        rchk("idle halt", 6'h02, v);
        wr(6'h00, 16'h8000);
        rd(6'h02, v);
        rchk("idle run", 6'h02, v + 16'h0002);
        @(posedge clk) idle_mode <= 1'b0;
        $display("test idle done");
        // gated accumulation on the internal clock
        wr(6'h00, 16'h8040);
        wr(6'h03, 16'h0001);
        rd(6'h02, v);
        rchk("gate closed", 6'h02, v);
        pins(0, 1'b1, 20);
        pins(0, 1'b0, 8);
        chk("gate fall flag", 16'h0001, {15'h0, irq_flag[0]});
        rd(6'h02, w);
        chk("gated count", 16'h0001, {15'h0, (w - v) >= 18 && (w - v) <= 24});
        $display("test gate done");
        // external pin clock: synced, gate ignored, unsynced in sleep
        for (int m = 0; m < 3; m++) begin
            wr(6'h00, m == 0 ? 16'h8006 : m == 1 ? 16'h8046 : 16'h8002);
            wr(6'h02, 16'h0000);
            sleep_mode <= (m == 2);
            repeat (5) begin
                pins(0, 1'b1, 3);
                pins(0, 1'b0, 3);
            end
            repeat (6) @(posedge clk);
            rchk("edge count", 6'h02, 16'h0005);
            sleep_mode <= 1'b0;
        end
        wr(6'h00, 16'h0000);
        $display("test external clock done");
        // 32-bit pair: carry into the odd word
        wr(6'h08, 16'h0030);
        wr(6'h05, 16'h0000);
        wr(6'h09, 16'h0005);
        wr(6'h06, 16'hFFFE);
        wr(6'h0A, 16'h0000);
        wr(6'h04, 16'h8008);
        repeat (3) @(posedge clk);
        wr(6'h04, 16'h0008);
        rchk("pair high word", 6'h0A, 16'h0001);
        rd(6'h06, v);
        chk("pair low word", 16'h0001, {15'h0, v < 16'h0010});
        chk("timebase lo", 16'h0003, timebase_lo);
        chk("timebase hi", 16'h0001, timebase_hi);
        // 32-bit match reported on the odd flag only
        wr(6'h05, 16'h0002);
        wr(6'h09, 16'h0001);
        wr(6'h06, 16'hFFFE);
        wr(6'h0A, 16'h0000);
        wr(6'h03, 16'h0006);
        clear_trig();
        idle_mode <= 1'b1;
        wr(6'h04, 16'h8008);
        wait_flag(2, 40, lat);
        chk("pair odd flag", 16'h0001, {15'h0, irq_flag[2]});
        chk("pair even flag", 16'h0000, {15'h0, irq_flag[1]});
        chk("converter trigger", 16'h0001, {15'h0, trig_seen[0]});
        chk("pair dma trigger", 16'h0002, {14'h0, trig_seen[3:2]});
        idle_mode <= 1'b0;
        $display("test pair done");
        // split again: even timer alone, odd timer idle
        wr(6'h04, 16'h0000);
        wr(6'h08, 16'h0000);
        wr(6'h05, 16'h0002);
        wr(6'h06, 16'h0000);
        wr(6'h03, 16'h0006);
        clear_trig();
        wr(6'h04, 16'h8000);
        wait_flag(1, 20, lat);
        chk("split even flag", 16'h0001, {15'h0, irq_flag[1]});
        rd(6'h0A, v);
        rchk("split odd still", 6'h0A, v);
        chk("split dma trigger", 16'h0001, {14'h0, trig_seen[3:2]});
        $display("test split done");
        // second pair, odd timer alone, feeds the second converter trigger
        clear_trig();
        wr(6'h11, 16'h0001);
        wr(6'h12, 16'h0000);
        wr(6'h10, 16'h8000);
        wait_flag(4, 20, lat);
        chk("second converter trigger", 16'h0001, {15'h0, trig_seen[1]});
        $display("test second pair done");
        report_and_stop();
    end
endmodule // tb_gpt_timer_set

/* File: rtl/gpt_pkg.sv */
// gpt_pkg: register map, control field layout and bus carrier for the timer set
// assumes a single 100 MHz clock domain and a plain address/strobe register port
package gpt_pkg;

    // ==========================================================
    // register map
    localparam int ADDR_W = 6;                      // word index width
    localparam int DATA_W = 16;                     // register width
    localparam int IDX_W = 4;                       // timer index field of the address
    localparam logic [1:0] OFS_CTRL = 2'h0;         // control word of a timer
    localparam logic [1:0] OFS_PERIOD = 2'h1;       // period word of a timer
    localparam logic [1:0] OFS_COUNT = 2'h2;        // count word of a timer
    localparam logic [5:0] ADDR_FLAGS = 6'h03;      // sticky match/gate flags

    // ==========================================================
    // writable bit masks and reset values
    localparam logic [15:0] MASK_SOLO = 16'hA076;   // run, idle, gate, prescale, sync, source
    localparam logic [15:0] MASK_EVEN = 16'hA07A;   // run, idle, gate, prescale, pair, source
    localparam logic [15:0] MASK_ODD = 16'hA072;    // run, idle, gate, prescale, source
    localparam logic [15:0] CTRL_RST = 16'h0000;
    localparam logic [15:0] PERIOD_RST = 16'hFFFF;
    localparam logic [15:0] COUNT_RST = 16'h0000;

    // ==========================================================
    // prescaler terminal counts (ratio minus one)
    localparam logic [7:0] PRE_T1 = 8'h00;
    localparam logic [7:0] PRE_T8 = 8'h07;
    localparam logic [7:0] PRE_T64 = 8'h3F;
    localparam logic [7:0] PRE_T256 = 8'hFF;

    // prescale ratio codes
    typedef enum logic [1:0] {
        GPT_PS_1 = 2'b00,
        GPT_PS_8 = 2'b01,
        GPT_PS_64 = 2'b10,
        GPT_PS_256 = 2'b11
    } gpt_presc_t;

    // control word, bit 15 down to bit 0
    typedef struct packed {
        logic timer_run;              // bit 15
        logic rsv14;
        logic idle_halt;              // bit 13
        logic [5:0] rsv12_7;
        logic gate_accum_enable;      // bit 6
        gpt_presc_t prescale_select;  // bits 5-4
        logic pair_mode_select;       // bit 3
        logic ext_clock_sync_select;  // bit 2
        logic clock_source_select;    // bit 1
        logic rsv0;
    } gpt_ctrl_t;

    // register port request, all strobes one cycle
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } gpt_bus_req_t;

endpackage

/* File: rtl/gpt_timer_set.sv */
// gpt_timer_set: one standalone 16-bit timer plus pairable 16/32-bit timer units
// assumes clk at 100 MHz, srst synchronous, pins asynchronous to clk
//
// Overview of operation
// R1: solo timer: timer, sync or async counter
// R2: solo flag on period match or gate fall
// R3: run bit 15 starts and stops counting
// R4: idle-halt bit 13 stops timer in idle
// R5: gate enable ignored with external clock
// R6: prescale bits 5-4 divide 1/8/64/256
// R7: sync bit 2 selects synchronised external clock
// R8: source bit 1 picks pin rising edge
// R9: software sets mode, period, interrupt first
// R10: unit is two 16-bit or one 32-bit
// R11: pair offers 32-bit timer and counter
// R12: even timer low half, odd high half
// R13: pair ignores odd timer control and pins
// R14: pair interrupt reported on odd flag
// R15: odd period high, even period low half
// R16: 32-bit count readable, odd word high
// R17: pair bit joins; clearing splits timers
// R18: software sets run bit last
// R19: pair flags on 32-bit period match
// R20: pair 0/1 trigger converters 0/1
// R21: only first pair: time base, DMA
// R22: timers run in idle and sleep; here only the async solo timer runs in sleep
// R23: pair bit 3 of even control register
// R24: software clears idle-halt for idle pair
// R25: match returns count to zero, continues
// R26: gated mode counts only while gate high
`timescale 1ns/1ps

// ==========================================================
// per-timer clock front end: pin sync, source select, prescaler
module gpt_chan #(
    parameter bit ALLOW_ASYNC = 1'b0
) (
    input wire logic clk,
    input wire logic srst,
    input wire gpt_pkg::gpt_ctrl_t ctrl,
    input wire logic pin,
    input wire logic idle_mode,
    input wire logic sleep_mode,
    output logic tick,
    output logic gate_fall,
    output logic gated,
    output logic gate_lvl
);
    logic pin_s1;       // first sync stage
    logic pin_s2;       // second sync stage
    logic pin_s3;       // previous level for edges
    logic run_async;    // counter keeps going through sleep
    logic halted;       // stopped by power mode
    logic src;          // one source event this cycle
    logic enable;       // event reaches the prescaler
    logic [7:0] pre;    // prescaler count
    logic [7:0] term;   // prescaler terminal

    // pin synchroniser, no logic reads the first stage
    always_ff @(posedge clk) begin
        if (srst) begin
            pin_s1 <= 1'b0;
            pin_s2 <= 1'b0;
            pin_s3 <= 1'b0;
        end else begin
            pin_s1 <= pin;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
        end
    end

    // source, gating and power-mode qualification
    always_comb begin
        gated = ctrl.gate_accum_enable & ~ctrl.clock_source_select; // R5
        run_async = ALLOW_ASYNC & ctrl.clock_source_select & ~ctrl.ext_clock_sync_select; // R7
        halted = (idle_mode & ctrl.idle_halt) | (sleep_mode & ~run_async); // R4 R22
        if (ctrl.clock_source_select) begin
            src = pin_s2 & ~pin_s3; // R8
        end else begin
            src = ~gated | pin_s2; // R26
        end
        enable = ctrl.timer_run & ~halted & src; // R3
        gate_lvl = pin_s2;
        gate_fall = gated & ctrl.timer_run & pin_s3 & ~pin_s2; // R2
    end

    // terminal count per ratio
    always_comb begin
        case (ctrl.prescale_select) // R6
            gpt_pkg::GPT_PS_1: term = gpt_pkg::PRE_T1;
            gpt_pkg::GPT_PS_8: term = gpt_pkg::PRE_T8;
            gpt_pkg::GPT_PS_64: term = gpt_pkg::PRE_T64;
            gpt_pkg::GPT_PS_256: term = gpt_pkg::PRE_T256;
            default: term = gpt_pkg::PRE_T1;
        endcase
    end

    // prescaler, cleared while stopped
    always_ff @(posedge clk) begin
        if (srst || !ctrl.timer_run) begin
            pre <= 8'h00;
        end else if (enable) begin
            pre <= (pre >= term) ? 8'h00 : pre + 8'h01; // R6
        end
    end

    // count event out
    assign tick = enable && (pre >= term);
endmodule // gpt_chan

// ==========================================================
// top: register port, counters, flags, event outputs
module gpt_timer_set #(
    parameter int NUM_PAIRS = 4
) (
    input wire logic clk,
    input wire logic srst,
    input wire gpt_pkg::gpt_bus_req_t bus_req,
    output logic [15:0] rd_data,
    input wire logic idle_mode,
    input wire logic sleep_mode,
    input wire logic [2*NUM_PAIRS:0] ext_pin,
    output logic [2*NUM_PAIRS:0] irq_flag,
    output logic [1:0] conv_trigger,
    output logic [1:0] dma_trigger,
    output logic [15:0] timebase_lo,
    output logic [15:0] timebase_hi
);
    localparam int NT = 2 * NUM_PAIRS + 1; // timer 0 solo, then pairs
    gpt_pkg::gpt_ctrl_t ctrl [NT];  // control words
    logic [15:0] per [NT];          // period words
    logic [15:0] cnt [NT];          // live counts
    logic [NT-1:0] mt;              // registered match pulses
    logic [NT-1:0] tick;            // count events
    logic [NT-1:0] gfall;           // gate falling edges
    logic [NT-1:0] gated;           // gated mode active
    logic [NT-1:0] glvl;            // synced gate level
    logic [NT-1:0] sel;             // address hits timer
    logic [NT-1:0] cnt_wr;          // count word write
    logic [NT-1:0] ev;              // flag set events
    logic [NT-1:0] flags;           // sticky flags
    logic [1:0] ofs;                // word within timer

    // step a 16-bit count: match bit over next value
    function automatic logic [16:0] gpt_step(input logic [15:0] c, input logic [15:0] p);
        logic m;
        m = (c == p);
        gpt_step = {m, m ? 16'h0000 : c + 16'h0001}; // R25
    endfunction
    assign ofs = bus_req.addr[1:0];

    // ==========================================================
    // address decode and clock front ends
    for (genvar i = 0; i < NT; i++) begin : g_chan
        assign sel[i] = (bus_req.addr[5:2] == 4'(i));
        assign cnt_wr[i] = bus_req.wr && sel[i] && (ofs == gpt_pkg::OFS_COUNT);
        gpt_chan #(
            .ALLOW_ASYNC(i == 0) // R1 R10
        ) u_chan (
            .clk(clk),
            .srst(srst),
            .ctrl(ctrl[i]),
            .pin(ext_pin[i]),
            .idle_mode(idle_mode),
            .sleep_mode(sleep_mode),
            .tick(tick[i]),
            .gate_fall(gfall[i]),
            .gated(gated[i]),
            .gate_lvl(glvl[i])
        );
    end

    // ==========================================================
    // control and period registers
    always_ff @(posedge clk) begin
        for (int i = 0; i < NT; i++) begin
            if (srst) begin
                ctrl[i] <= gpt_pkg::CTRL_RST;
                per[i] <= gpt_pkg::PERIOD_RST;
            end else if (bus_req.wr && sel[i]) begin
                if (ofs == gpt_pkg::OFS_CTRL) begin
                    ctrl[i] <= bus_req.wdata & (i == 0 ? gpt_pkg::MASK_SOLO // R23
                        : (i % 2 == 1) ? gpt_pkg::MASK_EVEN : gpt_pkg::MASK_ODD);
                end else if (ofs == gpt_pkg::OFS_PERIOD) begin
                    per[i] <= bus_req.wdata;
                end
            end
        end
    end

    // ==========================================================
    // standalone timer counter
    logic [15:0] c_solo;
    logic m_solo;
    logic [16:0] s_solo;
    assign s_solo = gpt_step(c_solo, per[0]);

    // count, wrap on period, software load wins
    always_ff @(posedge clk) begin
        if (srst) begin
            c_solo <= gpt_pkg::COUNT_RST;
            m_solo <= 1'b0;
        end else begin
            m_solo <= 1'b0;
            if (tick[0]) begin
                c_solo <= s_solo[15:0]; // R1 R25
                m_solo <= s_solo[16];
            end
            if (cnt_wr[0]) begin
                c_solo <= bus_req.wdata;
            end
        end
    end
    assign cnt[0] = c_solo;
    assign mt[0] = m_solo;
    assign ev[0] = gated[0] ? gfall[0] : m_solo; // R2

    // ==========================================================
    // pairable units
    for (genvar p = 0; p < NUM_PAIRS; p++) begin : g_pair
        localparam int LO = 1 + 2 * p;
        localparam int HI = 2 + 2 * p;
        logic [15:0] c_lo;
        logic [15:0] c_hi;
        logic m_lo;
        logic m_hi;
        logic [31:0] c32;
        logic [31:0] p32;
        logic [16:0] s_lo;
        logic [16:0] s_hi;
        logic joined;

        assign joined = ctrl[LO].pair_mode_select; // R17 R23
        assign c32 = {c_hi, c_lo}; // R12 R16
        assign p32 = {per[HI], per[LO]}; // R15
        assign s_lo = gpt_step(c_lo, per[LO]);
        assign s_hi = gpt_step(c_hi, per[HI]);

        // 32-bit uses even timer tick only, else halves run alone
        always_ff @(posedge clk) begin
            if (srst) begin
                c_lo <= gpt_pkg::COUNT_RST;
                c_hi <= gpt_pkg::COUNT_RST;
                m_lo <= 1'b0;
                m_hi <= 1'b0;
            end else begin
                m_lo <= 1'b0;
                m_hi <= 1'b0;
                if (joined) begin
                    if (tick[LO]) begin // R13 R11
                        if (c32 == p32) begin
                            c_lo <= 16'h0000; // R19 R25
                            c_hi <= 16'h0000;
                            m_hi <= 1'b1; // R14
                        end else begin
                            {c_hi, c_lo} <= c32 + 32'h0000_0001; // R12
                        end
                    end
                end else begin
                    if (tick[LO]) begin // R10
                        c_lo <= s_lo[15:0];
                        m_lo <= s_lo[16];
                    end
                    if (tick[HI]) begin
                        c_hi <= s_hi[15:0];
                        m_hi <= s_hi[16];
                    end
                end
                if (cnt_wr[LO]) begin
                    c_lo <= bus_req.wdata;
                end
                if (cnt_wr[HI]) begin
                    c_hi <= bus_req.wdata;
                end
            end
        end

        assign cnt[LO] = c_lo;
        assign cnt[HI] = c_hi;
        assign mt[LO] = m_lo;
        assign mt[HI] = m_hi;
        // even flag silent while joined, odd flag carries the pair
        assign ev[LO] = joined ? 1'b0 : (gated[LO] ? gfall[LO] : m_lo); // R14
        assign ev[HI] = joined ? (gated[LO] ? gfall[LO] : m_hi) // R13
                               : (gated[HI] ? gfall[HI] : m_hi);
    end

    // ==========================================================
    // sticky flags: write one to clear, a new event wins
    always_ff @(posedge clk) begin
        if (srst) begin
            flags <= '0;
        end else if (bus_req.wr && bus_req.addr == gpt_pkg::ADDR_FLAGS) begin
            flags <= (flags & ~bus_req.wdata[NT-1:0]) | ev;
        end else begin
            flags <= flags | ev; // R2 R19
        end
    end

    // ==========================================================
    // read port, data one cycle after the strobe
    always_ff @(posedge clk) begin
        if (srst) begin
            rd_data <= 16'h0000;
        end else begin
            rd_data <= 16'h0000;
            if (bus_req.rd && bus_req.addr == gpt_pkg::ADDR_FLAGS) begin
                rd_data <= 16'(flags);
            end else if (bus_req.rd) begin
                for (int i = 0; i < NT; i++) begin
                    if (sel[i]) begin
                        case (ofs)
                            gpt_pkg::OFS_CTRL: rd_data <= ctrl[i];
                            gpt_pkg::OFS_PERIOD: rd_data <= per[i];
                            gpt_pkg::OFS_COUNT: rd_data <= cnt[i]; // R16
                            default: rd_data <= 16'h0000;
                        endcase
                    end
                end
            end
        end
    end

    // ==========================================================
    // outputs toward converters, capture/compare and DMA
    assign irq_flag = flags;
    assign conv_trigger = {mt[4], mt[2]}; // R20
    assign dma_trigger = {mt[2], mt[1]}; // R21
    assign timebase_lo = cnt[1]; // R21
    assign timebase_hi = cnt[2];

    // ==========================================================
    // checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    chk_run_hold: assert property (!ctrl[0].timer_run && !cnt_wr[0] |=> $stable(cnt[0])) // R3
        else $error("stopped timer count moved");
    chk_period_wrap: assert property (tick[0] && cnt[0] == per[0] && !cnt_wr[0] // R25
        |=> cnt[0] == 16'h0000 && mt[0]) else $error("count did not wrap on match");
    chk_flag_set: assert property (ev[0] |=> flags[0]) // R2
        else $error("flag not set after event");
    chk_flag_keep: assert property (flags[0] && !(bus_req.wr && sel[0] && ofs == 2'h3) // R2
        |=> flags[0]) else $error("flag dropped without a clear");
    chk_gate_low: assert property (gated[0] && !glvl[0] |-> !tick[0]) // R26
        else $error("gated timer counted with gate low");
    chk_idle_stop: assert property (idle_mode && ctrl[0].idle_halt |-> !tick[0]) // R4
        else $error("timer counted in idle with halt set");
    chk_ext_gate: assert property (ctrl[0].clock_source_select |-> !gfall[0] && !gated[0]) // R5
        else $error("gate active with external clock");
    chk_sync_sleep: assert property (sleep_mode && ctrl[0].ext_clock_sync_select // R7
        |-> !tick[0]) else $error("synchronised counter ran in sleep");
    chk_ps_eight: assert property (tick[0] && ctrl[0].prescale_select == gpt_pkg::GPT_PS_8 // R6
        |=> (!tick[0] || ctrl[0].prescale_select != gpt_pkg::GPT_PS_8) [*7])
        else $error("divide by eight ticked early");
    chk_pair_lo_quiet: assert property (ctrl[1].pair_mode_select |-> !ev[1]) // R14
        else $error("even flag raised in 32-bit mode");
    chk_pair_carry: assert property (ctrl[1].pair_mode_select && tick[1] // R12
        && cnt[1] == 16'hFFFF && {cnt[2], cnt[1]} != {per[2], per[1]} && !cnt_wr[1] && !cnt_wr[2]
        |=> cnt[1] == 16'h0000 && cnt[2] == $past(cnt[2]) + 16'h0001)
        else $error("low half did not carry into high half");
    chk_read_cnt: assert property (bus_req.rd && bus_req.addr == {4'h2, gpt_pkg::OFS_COUNT} // R16
        |=> rd_data == $past(cnt[2])) else $error("high count word read wrong");

    cov_pair_match: cover property (ctrl[1].pair_mode_select && mt[2]);
    cov_gate_fall: cover property (gfall[0] ##1 flags[0]);
    cov_async_sleep: cover property (sleep_mode && tick[0]);
    cov_flag_clear: cover property (flags[0] ##1 !flags[0]);
endmodule // gpt_timer_set
